// file: lam_core.sv
// lam_core: trunk group table, load spreading with failover, master-port
// setting propagation and single-port mirroring.
// assumes MAC events and port settings arrive on core_clk; link_up is a pin.
//
// Overview of operation
// RULE_01: up to six groups, each selected by number and holding a name.
// RULE_02: a group naming more than eight members is refused.
// RULE_03: membership is a per-port flag, members need not be consecutive.
// RULE_04: software places only ports of one common VLAN in a group.
// RULE_05: software groups only equal-speed ports, preferably full duplex.
// RULE_06: lowest numbered member of a group is its master port.
// RULE_07: master port settings replace every member's own settings.
// RULE_08: outgoing group traffic is spread over members automatically.
// RULE_09: a failed member link moves its traffic to remaining live members.
// RULE_10: spanning tree sees each group as one single link.
// RULE_11: group cost and forwarding state come only from the master port.
// RULE_12: blocking a redundant group blocks all its members together.
// RULE_13: each group shows a member flag for each port, three banks of eight.
// RULE_14: group enable resets off; aggregation acts only while it is set.
// RULE_15: while mirroring is on, source port frames are copied to target.
// RULE_16: direction picks receive, transmit or both; default both, enable off.
// RULE_17: a mirror target that belongs to any group is refused.
// RULE_18: software keeps mirror source speed at or below target speed.
// RULE_19: group settings are selected by number and stored only on apply.
// RULE_20: member is picked by hashing addresses so conversations keep order.
// RULE_21: mirror copies never alter, delay or drop the original frames.
`timescale 1ns/1ps
`default_nettype none
module lam_core
    import lam_pkg::*;
#(
    parameter int NAME_W = 64,
    parameter int CFG_W = 16,
    parameter int COST_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // group configuration
    input wire logic cfg_apply,
    input wire logic [LAM_GW-1:0] cfg_grp,
    input wire logic [NAME_W-1:0] cfg_name,
    input wire logic [LAM_NPORT-1:0] cfg_members,
    input wire logic cfg_enable,
    output logic cfg_ack,
    output logic cfg_reject,
    // group status
    output logic [LAM_NGRP*NAME_W-1:0] grp_names,
    output logic [LAM_NGRP*LAM_NPORT-1:0] grp_members,
    output logic [LAM_NGRP-1:0] grp_enabled,
    output logic [LAM_NGRP*LAM_PW-1:0] grp_master,
    // mirror configuration
    input wire logic mir_apply,
    input wire logic [LAM_PW-1:0] mir_src,
    input wire logic [LAM_PW-1:0] mir_tgt,
    input wire logic [1:0] mir_dir,
    input wire logic mir_enable,
    output logic mir_ack,
    output logic mir_reject,
    output logic mir_active,
    // per-port link state and settings
    input wire logic [LAM_NPORT-1:0] link_up,
    input wire logic [LAM_NPORT*CFG_W-1:0] port_cfg,
    input wire logic [LAM_NPORT*LAM_STPW-1:0] port_stp,
    input wire logic [LAM_NPORT*COST_W-1:0] port_cost,
    output logic [LAM_NPORT*CFG_W-1:0] eff_cfg,
    output logic [LAM_NPORT*LAM_STPW-1:0] eff_stp,
    output logic [LAM_NPORT*COST_W-1:0] eff_cost,
    // egress port resolution
    input wire logic fwd_valid,
    input wire logic [LAM_PW-1:0] fwd_dst,
    input wire logic [47:0] fwd_key,
    output logic out_valid,
    output logic [LAM_PW-1:0] out_port,
    output logic out_drop,
    // mirror frame events
    input wire logic [LAM_NPORT-1:0] rx_sof,
    input wire logic [LAM_NPORT-1:0] tx_sof,
    output logic mir_rx_copy,
    output logic mir_tx_copy,
    output logic [LAM_PW-1:0] mir_port
);

    function automatic logic [LAM_PW-1:0] popcnt(input logic [LAM_NPORT-1:0] m);
        logic [LAM_PW-1:0] c;
        c = '0;
        for (int i = 0; i < LAM_NPORT; i++) begin
            c = c + LAM_PW'(m[i]);
        end
        return c;
    endfunction

    // index of the k-th set bit, counting from the lowest port
    function automatic logic [LAM_PW-1:0] nth_set(input logic [LAM_NPORT-1:0] m,
                                                  input logic [LAM_PW-1:0] k);
        logic [LAM_PW-1:0] c;
        logic [LAM_PW-1:0] r;
        c = '0;
        r = '0;
        for (int i = LAM_NPORT - 1; i >= 0; i--) begin
            if (m[i] && popcnt(m & ((LAM_NPORT'(1) << i) - LAM_NPORT'(1))) == k) begin
                r = LAM_PW'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [LAM_HASHW-1:0] fold(input logic [47:0] k);
        logic [LAM_HASHW-1:0] h;
        h = '0;
        for (int i = 0; i < 48 / LAM_HASHW; i++) begin
            h = h ^ k[i*LAM_HASHW +: LAM_HASHW];
        end
        return h;
    endfunction

    // reset release through two flops
    logic rst_meta_ff;
    logic rst_sync_b_ff;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_b_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_b_ff <= rst_meta_ff;
        end
    end

    // link pins are asynchronous to the core
    logic [LAM_NPORT-1:0] link_meta_ff;
    logic [LAM_NPORT-1:0] link_ff;
    always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
            link_meta_ff <= '0;
            link_ff <= '0;
        end else begin
            link_meta_ff <= link_up;
            link_ff <= link_meta_ff;
        end
    end

    logic [NAME_W-1:0] name_ff [LAM_NGRP];
    logic [LAM_NPORT-1:0] mem_ff [LAM_NGRP];
    logic [LAM_NGRP-1:0] en_ff;
    logic [LAM_PW-1:0] mir_src_ff;
    logic [LAM_PW-1:0] mir_tgt_ff;
    logic [1:0] mir_dir_ff;
    logic mir_en_ff;

    logic [LAM_NPORT-1:0] any_mem;
    logic [LAM_NPORT-1:0] other_mem;
    logic [LAM_PW-1:0] master_c [LAM_NGRP];
    logic [LAM_GW-1:0] grp_of [LAM_NPORT];
    logic cfg_bad;
    logic mir_bad;

    always_comb begin
        any_mem = '0;
        other_mem = '0;
        for (int g = 0; g < LAM_NGRP; g++) begin
            any_mem = any_mem | mem_ff[g];
            if (LAM_GW'(g) != cfg_grp) begin
                other_mem = other_mem | mem_ff[g];
            end
            master_c[g] = nth_set(mem_ff[g], '0); // RULE_06
        end
        for (int p = 0; p < LAM_NPORT; p++) begin
            grp_of[p] = LAM_NO_GRP;
            for (int g = 0; g < LAM_NGRP; g++) begin
                if (en_ff[g] && mem_ff[g][p]) begin // RULE_14
                    grp_of[p] = LAM_GW'(g);
                end
            end
        end
        // a port in two groups, or the live mirror target, would break both
        cfg_bad = (cfg_grp >= LAM_GW'(LAM_NGRP)) // RULE_01
            || (popcnt(cfg_members) > LAM_PW'(LAM_MAXMEM)) // RULE_02
            || ((cfg_members & other_mem) != '0)
            || (mir_en_ff && cfg_members[mir_tgt_ff]);
        mir_bad = (mir_src >= LAM_PW'(LAM_NPORT)) || (mir_tgt >= LAM_PW'(LAM_NPORT))
            || (mir_src == mir_tgt) || (mir_tgt < LAM_PW'(LAM_NPORT) && any_mem[mir_tgt]);
    end

    // group table written only by an accepted apply
    always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
            for (int g = 0; g < LAM_NGRP; g++) begin
                name_ff[g] <= '0;
                mem_ff[g] <= '0;
                en_ff[g] <= LAM_GRP_EN_RST; // RULE_14
            end
            cfg_ack <= 1'b0;
            cfg_reject <= 1'b0;
        end else begin
            cfg_ack <= cfg_apply && !cfg_bad;
            cfg_reject <= cfg_apply && cfg_bad;
            if (cfg_apply && !cfg_bad) begin // RULE_19
                name_ff[cfg_grp] <= cfg_name; // RULE_01
                mem_ff[cfg_grp] <= cfg_members; // RULE_03
                en_ff[cfg_grp] <= cfg_enable;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
            mir_src_ff <= LAM_MIR_SRC_RST;
            mir_tgt_ff <= LAM_MIR_TGT_RST;
            mir_dir_ff <= LAM_DIR_RST; // RULE_16
            mir_en_ff <= LAM_MIR_EN_RST;
            mir_ack <= 1'b0;
            mir_reject <= 1'b0;
        end else begin
            mir_ack <= mir_apply && !mir_bad;
            mir_reject <= mir_apply && mir_bad; // RULE_17
            if (mir_apply && !mir_bad) begin
                mir_src_ff <= mir_src;
                mir_tgt_ff <= mir_tgt;
                mir_dir_ff <= mir_dir;
                mir_en_ff <= mir_enable;
            end
        end
    end

    // status: member flags laid out port by port, banks of eight per group
    always_comb begin
        for (int g = 0; g < LAM_NGRP; g++) begin
            grp_names[g*NAME_W +: NAME_W] = name_ff[g];
            grp_members[g*LAM_NPORT +: LAM_NPORT] = mem_ff[g]; // RULE_13
            grp_master[g*LAM_PW +: LAM_PW] = master_c[g];
        end
        grp_enabled = en_ff;
        mir_active = mir_en_ff;
    end

    // every member of an enabled group takes its master's settings, cost and tree state, so the
    // tree engine sees one link and blocks the whole group at once
    always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
            eff_cfg <= '0;
            eff_stp <= '0;
            eff_cost <= '0;
        end else begin
            for (int p = 0; p < LAM_NPORT; p++) begin
                int s;
                s = (grp_of[p] == LAM_NO_GRP) ? p : int'(master_c[grp_of[p]]);
                eff_cfg[p*CFG_W +: CFG_W] <= port_cfg[s*CFG_W +: CFG_W]; // RULE_07
                eff_stp[p*LAM_STPW +: LAM_STPW] <= port_stp[s*LAM_STPW +: LAM_STPW]; // RULE_10
                eff_cost[p*COST_W +: COST_W] <= port_cost[s*COST_W +: COST_W]; // RULE_11
            end
        end
    end

    // egress: a group destination becomes one live member picked by hash
    logic [LAM_GW-1:0] fwd_grp;
    logic [LAM_NPORT-1:0] fwd_live;
    logic [LAM_PW-1:0] fwd_cnt;
    logic [LAM_PW-1:0] fwd_pick;
    logic fwd_none;
    always_comb begin
        fwd_grp = (fwd_dst < LAM_PW'(LAM_NPORT)) ? grp_of[fwd_dst] : LAM_NO_GRP;
        fwd_live = '0;
        if (fwd_grp != LAM_NO_GRP) begin
            fwd_live = mem_ff[fwd_grp] & link_ff; // RULE_09
        end
        fwd_cnt = popcnt(fwd_live);
        fwd_none = (fwd_grp != LAM_NO_GRP) && (fwd_cnt == '0);
        fwd_pick = fwd_dst;
        if (fwd_grp != LAM_NO_GRP && !fwd_none) begin
            // same addresses give the same member while the set is unchanged
            fwd_pick = nth_set(fwd_live, LAM_PW'(fold(fwd_key) % LAM_HASHW'(fwd_cnt))); // RULE_20
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
            out_valid <= 1'b0;
            out_port <= '0;
            out_drop <= 1'b0;
        end else begin
            out_valid <= fwd_valid;
            out_port <= fwd_pick; // RULE_08
            out_drop <= fwd_valid && fwd_none;
        end
    end

    // mirroring only taps start-of-frame events; originals pass untouched
    logic mir_ok;
    assign mir_ok = mir_en_ff && !any_mem[mir_tgt_ff];
    always_ff @(posedge core_clk or negedge rst_sync_b_ff) begin
        if (!rst_sync_b_ff) begin
            mir_rx_copy <= 1'b0;
            mir_tx_copy <= 1'b0;
            mir_port <= '0;
        end else begin
            mir_rx_copy <= mir_ok && mir_dir_ff[LAM_DIR_RX_BIT] && rx_sof[mir_src_ff]; // RULE_15
            mir_tx_copy <= mir_ok && mir_dir_ff[LAM_DIR_TX_BIT] && tx_sof[mir_src_ff]; // RULE_21
            mir_port <= mir_tgt_ff;
        end
    end

    AST_GRP_RANGE: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_01
        cfg_apply && cfg_grp >= LAM_GW'(LAM_NGRP) |=> cfg_reject && !cfg_ack)
        else $error("group number out of range was accepted");
    AST_MEMBER_LIMIT: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_02
        cfg_apply && popcnt(cfg_members) > LAM_PW'(LAM_MAXMEM)
        |=> cfg_reject ##0 $stable(grp_members))
        else $error("more than eight members were accepted");
    AST_STORE: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_19
        cfg_apply && !cfg_bad |=> cfg_ack && grp_members[$past(cfg_grp)*LAM_NPORT +: LAM_NPORT]
        == $past(cfg_members))
        else $error("accepted membership not stored");
    AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_03
        !cfg_apply |=> $stable(grp_members) && $stable(grp_enabled))
        else $error("group table changed without apply");
    AST_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_14
        fwd_valid && fwd_grp == LAM_NO_GRP |=> out_port == $past(fwd_dst) && !out_drop)
        else $error("port outside an enabled group was redirected");
    AST_IN_GROUP: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_08
        fwd_valid && fwd_grp != LAM_NO_GRP |=> out_drop || $past(fwd_live[fwd_pick]))
        else $error("group traffic left on a non-member or dead link");
    AST_FAILOVER: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_09
        fwd_valid && fwd_grp != LAM_NO_GRP && fwd_live != '0 |=> !out_drop)
        else $error("frame dropped while a live member remained");
    AST_HASH_ORDER: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_20
        fwd_valid && $past(fwd_valid) && $stable(fwd_key) && $stable(fwd_dst)
        && $stable(link_ff) && !$past(cfg_apply) |=> $stable(out_port))
        else $error("one conversation moved between members");
    AST_MIR_TGT: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_17
        mir_apply && mir_tgt < LAM_PW'(LAM_NPORT) && any_mem[mir_tgt]
        // mir_port trails the stored target by one cycle, so compare one cycle later
        |=> mir_reject ##1 $stable(mir_port))
        else $error("trunk member accepted as mirror target");
    AST_MIR_COPY: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_15
        mir_ok && rx_sof[mir_src_ff] && mir_dir_ff[LAM_DIR_RX_BIT]
        |=> mir_rx_copy && mir_port == $past(mir_tgt_ff))
        else $error("received frame on source not copied");
    AST_MIR_OFF: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_16
        !mir_en_ff || mir_dir_ff == LAM_DIR_RX |=> !mir_tx_copy)
        else $error("transmit copy while disabled or receive-only");

    for (genvar g = 0; g < LAM_NGRP; g++) begin : g_ast
        AST_LOWEST: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_06
            mem_ff[g] != '0 |-> mem_ff[g][master_c[g]]
            && (mem_ff[g] & ((LAM_NPORT'(1) << master_c[g]) - LAM_NPORT'(1))) == '0)
            else $error("master is not the lowest member");
        for (genvar p = 0; p < LAM_NPORT; p++) begin : g_port
            AST_STP_MASTER: assert property (@(posedge core_clk) disable iff (!rst_sync_b_ff) // RULE_12
                en_ff[g] && mem_ff[g][p] |=> eff_stp[p*LAM_STPW +: LAM_STPW]
                == $past(port_stp[master_c[g]*LAM_STPW +: LAM_STPW]))
                else $error("member tree state differs from master");
        end
    end

    COV_GRP_OK: cover property (@(posedge core_clk) disable iff (!rst_sync_b_ff)
        cfg_apply ##1 cfg_ack);
    COV_FAILOVER: cover property (@(posedge core_clk) disable iff (!rst_sync_b_ff)
        $fell(link_ff[4]) ##[1:20] out_valid && !out_drop);
    COV_DROP: cover property (@(posedge core_clk) disable iff (!rst_sync_b_ff)
        out_valid && out_drop);
    COV_MIR: cover property (@(posedge core_clk) disable iff (!rst_sync_b_ff)
        mir_rx_copy && mir_tx_copy);
endmodule
`default_nettype wire

// file: lam_core_tb.sv
// lam_core_tb: self-checking bench for trunk groups, spreading and mirroring.
// assumes lam_core with default widths and the mac model beside it.
`timescale 1ns/1ps
`default_nettype none
module lam_core_tb;
    import lam_pkg::*;
    typedef struct packed {
        logic [2:0] g;
        logic [23:0] m;
        logic en;
        logic ok;
    } lam_row_s;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cfg_apply, cfg_enable, mir_apply, mir_enable, fwd_valid;
    logic cfg_ack, cfg_reject, mir_ack, mir_reject, mir_active, out_valid, out_drop;
    logic mir_rx_copy, mir_tx_copy;
    logic [2:0] cfg_grp;
    logic [63:0] cfg_name;
    logic [23:0] cfg_members, link_up, rx_sof, tx_sof;
    logic [4:0] mir_src, mir_tgt, fwd_dst, out_port, mir_port;
    logic [1:0] mir_dir;
    logic [47:0] fwd_key, port_stp, eff_stp;
    logic [383:0] port_cfg, eff_cfg, port_cost, eff_cost, grp_names;
    logic [143:0] grp_members;
    logic [5:0] grp_enabled, exp_en;
    logic [29:0] grp_master;
    logic [23:0] exp_mem [6];
    logic [4:0] dsts [8] = '{5'h02, 5'h04, 5'h08, 5'h11, 5'h14, 5'h0A, 5'h00, 5'h17};
    lam_row_s rows [6];
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    lam_core lam_core_i (.core_clk, .rst_b, .cfg_apply, .cfg_grp, .cfg_name, .cfg_members,
        .cfg_enable, .cfg_ack, .cfg_reject, .grp_names, .grp_members, .grp_enabled,
        .grp_master, .mir_apply, .mir_src, .mir_tgt, .mir_dir, .mir_enable, .mir_ack,
        .mir_reject, .mir_active, .link_up, .port_cfg, .port_stp, .port_cost, .eff_cfg,
        .eff_stp, .eff_cost, .fwd_valid, .fwd_dst, .fwd_key, .out_valid, .out_port,
        .out_drop, .rx_sof, .tx_sof, .mir_rx_copy, .mir_tx_copy, .mir_port);
    lam_mac_model lam_mac_model_i (.core_clk, .rx_sof, .tx_sof, .link_up);

    always #50 core_clk = ~core_clk;

    // the whole run needs under a hundred cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    // request is left standing so applies can run back to back
    task automatic cfg(input logic [2:0] g, input logic [23:0] m, input logic en);
        cfg_apply = 1'b1;
        cfg_grp = g;
        cfg_members = m;
        cfg_enable = en;
        cfg_name = {32'h5A5A5A5A, 29'h0, g};
        @(negedge core_clk);
    endtask

    task automatic cfg_chk(input lam_row_s r);
        chk("cfg_ack", r.ok, cfg_ack);
        chk("cfg_reject", !r.ok, cfg_reject);
        if (r.ok) begin
            exp_mem[r.g] = r.m;
            exp_en[r.g] = r.en;
            chk("grp_names", {32'h5A5A5A5A, 29'h0, r.g}, grp_names[r.g*64+:64]);
        end
        for (int g = 0; g < 6; g++) begin
            chk("grp_members", exp_mem[g], grp_members[g*24+:24]);
        end
        chk("grp_enabled", exp_en, grp_enabled);
    endtask

    function automatic int own(input int p);
        for (int g = 0; g < 6; g++) begin
            if (exp_en[g] && exp_mem[g][p]) begin
                for (int q = 0; q < 24; q++) begin
                    if (exp_mem[g][q]) return q;
                end
            end
        end
        return p;
    endfunction

    // {drop, port}: key bytes folded, then picked among live members in port order
    function automatic logic [5:0] exp_fwd(input logic [4:0] dst, input logic [47:0] key);
        logic [23:0] mem;
        logic [7:0] h;
        logic hit;
        int idx;
        mem = '0;
        hit = 1'b0;
        h = key[7:0] ^ key[15:8] ^ key[23:16] ^ key[31:24] ^ key[39:32] ^ key[47:40];
        for (int g = 0; g < 6; g++) begin
            if (exp_en[g] && exp_mem[g][dst]) begin
                hit = 1'b1;
                mem = exp_mem[g] & link_up;
            end
        end
        // ports outside every enabled group keep their own number
        if (!hit) return {1'b0, dst};
        if (mem == '0) return 6'h20;
        idx = h % $countones(mem);
        for (int p = 0; p < 24; p++) begin
            if (mem[p] && idx == 0) return {1'b0, 5'(p)};
            if (mem[p]) idx--;
        end
        return 6'h20;
    endfunction

    task automatic fwd(input logic [4:0] dst, input logic [47:0] key);
        logic [5:0] e;
        e = exp_fwd(dst, key);
        fwd_valid = 1'b1;
        fwd_dst = dst;
        fwd_key = key;
        @(negedge core_clk);
        chk("out_valid", 1'b1, out_valid);
        chk("out_drop", e[5], out_drop);
        if (!e[5]) begin
            chk("out_port", e[4:0], out_port);
        end
    endtask

    task automatic mir(input logic [4:0] s, input logic [4:0] t, input logic [1:0] d,
                       input logic en, input logic ok);
        mir_apply = 1'b1;
        mir_src = s;
        mir_tgt = t;
        mir_dir = d;
        mir_enable = en;
        @(negedge core_clk);
        chk("mir_ack", ok, mir_ack);
        chk("mir_reject", !ok, mir_reject);
        mir_apply = 1'b0;
        @(negedge core_clk);
    endtask

    // a frame on the given port while a forward request runs beside it
    task automatic copy(input int port, input logic [1:0] exp);
        fork
            fwd(5'h11, 48'h000000000003);
            lam_mac_model_i.frame(port, 1'b1, 1'b1);
        join
        fwd_valid = 1'b0;
        chk("mir_rx_copy", exp[0], mir_rx_copy);
        chk("mir_tx_copy", exp[1], mir_tx_copy);
    endtask

    initial begin
        {cfg_apply, cfg_enable, mir_apply, mir_enable, fwd_valid} = '0;
        {cfg_grp, cfg_name, cfg_members, mir_src, mir_tgt, mir_dir, fwd_dst, fwd_key} = '0;
        exp_en = '0;
        for (int p = 0; p < 24; p++) begin
            port_cfg[p*16+:16] = 16'h0100 + 16'(p);
            port_cost[p*16+:16] = 16'h0200 + 16'(p);
            port_stp[p*2+:2] = 2'(p);
        end
        for (int g = 0; g < 6; g++) begin
            exp_mem[g] = '0;
        end
        // members share one VLAN and one speed
        rows = '{'{3'h0, 24'h000114, 1'b1, 1'b1}, '{3'h6, 24'h000001, 1'b1, 1'b0},
                 '{3'h1, 24'hFF8000, 1'b1, 1'b0}, '{3'h1, 24'hFF0000, 1'b1, 1'b1},
                 '{3'h2, 24'h000004, 1'b1, 1'b0}, '{3'h5, 24'h000400, 1'b0, 1'b1}};
        repeat (3) @(negedge core_clk);
        chk("grp_enabled", 6'h00, grp_enabled);
        chk("mir_active", 1'b0, mir_active);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        for (int i = 0; i < 6; i++) begin
            cfg(rows[i].g, rows[i].m, rows[i].en);
            cfg_chk(rows[i]);
        end
        cfg_apply = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("grp_master", 5'h02, grp_master[0+:5]);
        chk("grp_master", 5'h10, grp_master[5+:5]);
        for (int p = 0; p < 24; p++) begin
            chk("eff_cfg", port_cfg[own(p)*16+:16], eff_cfg[p*16+:16]);
            chk("eff_stp", port_stp[own(p)*2+:2], eff_stp[p*2+:2]);
            chk("eff_cost", port_cost[own(p)*16+:16], eff_cost[p*16+:16]);
        end
        // all links up, then one member down, then group 0 dark
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 8; i++) begin
                fwd(dsts[i], 48'h123456000000 + 48'(i * 37 + k));
            end
            fwd_valid = 1'b0;
            lam_mac_model_i.set_link(k == 0 ? 24'hFFFFEF : 24'hFFFEEB);
            repeat (4) @(negedge core_clk);
        end
        lam_mac_model_i.set_link(24'hFFFFFF);
        repeat (4) @(negedge core_clk);
        mir(5'h00, 5'h0A, 2'h3, 1'b1, 1'b0);
        mir(5'h05, 5'h05, 2'h3, 1'b1, 1'b0);
        for (int d = 0; d < 4; d++) begin
            mir(5'h01, 5'h0C, 2'(d), 1'b1, 1'b1);
            chk("mir_active", 1'b1, mir_active);
            chk("mir_port", 5'h0C, mir_port);
            copy(1, 2'(d));
        end
        copy(3, 2'h0);
        cfg(3'h2, 24'h001000, 1'b1);
        cfg_chk(lam_row_s'{3'h2, 24'h001000, 1'b1, 1'b0});
        cfg_apply = 1'b0;
        mir(5'h01, 5'h0C, 2'h3, 1'b0, 1'b1);
        chk("mir_active", 1'b0, mir_active);
        copy(1, 2'h0);
        mir(5'h01, 5'h0C, 2'h3, 1'b1, 1'b1);
        chk("mir_active", 1'b1, mir_active);
        rst_b = 1'b0;
        #1;
        chk("grp_enabled", 6'h00, grp_enabled);
        chk("mir_active", 1'b0, mir_active);
        end_sim();
    end
endmodule
`default_nettype wire

// file: lam_mac_model.sv
// lam_mac_model: stand-in for the port MACs and the link pins around the core.
// assumes the bench calls its tasks at a falling edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module lam_mac_model
    import lam_pkg::*;
(
    // clock
    input wire logic core_clk,
    // frame starts and link pins
    output logic [LAM_NPORT-1:0] rx_sof,
    output logic [LAM_NPORT-1:0] tx_sof,
    output logic [LAM_NPORT-1:0] link_up
);
    // every port runs at one speed in full duplex, so any source suits any target
    initial begin
        rx_sof = '0;
        tx_sof = '0;
        link_up = '1;
    end

    // one-cycle start pulse, launched and dropped on falling edges
    task automatic frame(input int port, input logic rx, input logic tx);
        rx_sof[port] = rx;
        tx_sof[port] = tx;
        @(negedge core_clk);
        rx_sof = '0;
        tx_sof = '0;
    endtask

    task automatic set_link(input logic [LAM_NPORT-1:0] up);
        link_up = up;
    endtask
endmodule
`default_nettype wire

// file: lam_pkg.sv
// lam_pkg: shared constants for trunk aggregation and port mirroring.
// assumes one 10 MHz core clock and a 24-port switch fabric around it.
`default_nettype none
package lam_pkg;
    localparam int LAM_NPORT = 24;
    localparam int LAM_NGRP = 6;
    localparam int LAM_MAXMEM = 8;
    localparam int LAM_PW = 5;
    localparam int LAM_GW = 3;
    localparam int LAM_STPW = 2;
    localparam int LAM_HASHW = 8;
    localparam logic [2:0] LAM_NO_GRP = 3'h7;
    localparam int LAM_DIR_RX_BIT = 0;
    localparam int LAM_DIR_TX_BIT = 1;
    localparam logic [1:0] LAM_DIR_RX = 2'h1;
    localparam logic [1:0] LAM_DIR_TX = 2'h2;
    localparam logic [1:0] LAM_DIR_BOTH = 2'h3;
    localparam logic [1:0] LAM_DIR_RST = LAM_DIR_BOTH;
    localparam logic LAM_MIR_EN_RST = 1'b0;
    localparam logic LAM_GRP_EN_RST = 1'b0;
    localparam logic [4:0] LAM_MIR_SRC_RST = 5'h00;
    localparam logic [4:0] LAM_MIR_TGT_RST = 5'h01;
endpackage
`default_nettype wire
